// file: rtl/ecl_pkg.sv
// Constants shared by the port configuration loader and its helpers.
// Assumes a 10 MHz system clock and a serial memory of 16-bit words.
package ecl_pkg;
  // Structure
  localparam int NPORT = 4;
  localparam int NWORD = 10;
  localparam int DW    = 16;
  localparam int RW    = 32;
  localparam int MAW   = 6;
  localparam int WIW   = 4;
  // Memory byte addresses of the first loaded word and the word stride
  localparam logic [7:0] FIRST_ADDR = 8'h0C;
  localparam logic [7:0] ADDR_STEP  = 8'h02;
  // Word slots in load order
  localparam logic [WIW-1:0] W_CAP = 4'h0;
  localparam logic [WIW-1:0] W_MGN = 4'h1;
  localparam logic [WIW-1:0] W_NOM = 4'h2;
  localparam logic [WIW-1:0] W_EMP = 4'h3;
  localparam logic [WIW-1:0] W_PHY = 4'h4;
  localparam logic [WIW-1:0] W_C4L = 4'h5;
  localparam logic [WIW-1:0] W_C4H = 4'h6;
  localparam logic [WIW-1:0] W_C5L = 4'h7;
  localparam logic [WIW-1:0] W_C5H = 4'h8;
  localparam logic [WIW-1:0] W_DLT = 4'h9;
  // Word defaults, used until the memory has been read
  localparam logic [DW-1:0] DEF_CAP = 16'h001D;
  localparam logic [DW-1:0] DEF_MGN = 16'h916B;
  localparam logic [DW-1:0] DEF_NOM = 16'h0A73;
  localparam logic [DW-1:0] DEF_EMP = 16'hF6B5;
  localparam logic [DW-1:0] DEF_PHY = 16'hC0A7;
  localparam logic [DW-1:0] DEF_C4L = 16'h0000;
  localparam logic [DW-1:0] DEF_C4H = 16'h0000;
  localparam logic [DW-1:0] DEF_C5L = 16'h3333;
  localparam logic [DW-1:0] DEF_C5H = 16'h7B08;
  localparam logic [DW-1:0] DEF_DLT = 16'h0000;
  // Serial read: opcode, command length, sampled bits, half clock
  localparam logic [2:0] RD_OP    = 3'h6;
  localparam int         CMD_LEN  = 9;
  localparam int         RD_BITS  = 17;
  localparam int         SCK_HALF = 4;
  localparam int         BOOT_CYC = 3;
  // Destination bit positions
  localparam int CC_LBN   = 21;
  localparam int CC_SDN   = 19;
  localparam int C8_ORDF  = 6;
  localparam int C8_SOF   = 0;
  localparam int C8_PMDS  = 1;
  localparam int C8_4KB   = 3;
  localparam int C8_R2M   = 31;
  localparam int C8_P6LO  = 16;
  localparam int C8_P6MID = 17;
  localparam int C8_P6HI  = 21;
  localparam int E4_LTR   = 12;
  localparam int E4_OBFF  = 18;
  localparam int HI_FLD   = 16;
  localparam int C90_HSD  = 15;
  localparam int C90_LED  = 20;
  localparam int C98_RCB  = 16;
endpackage

// file: rtl/ecl_serial_reader.sv
// Reads one 16-bit word from a three-wire serial memory.
// Assumes mem_do_i is already synchronised and tick_i is a 1-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module ecl_serial_reader (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  // Control
  input  wire logic                 tick_i,
  input  wire logic                 start_i,
  input  wire logic [ecl_pkg::MAW-1:0] addr_i,
  output logic                      done_o,
  output logic [ecl_pkg::DW-1:0]    data_o,
  // Memory pins
  input  wire logic                 mem_do_i,
  output logic                      mem_cs_o,
  output logic                      mem_sck_o,
  output logic                      mem_di_o
);
  localparam logic [4:0] LAST =
    5'(ecl_pkg::CMD_LEN + ecl_pkg::RD_BITS);
  localparam logic [4:0] CMDL = 5'(ecl_pkg::CMD_LEN);

  logic [ecl_pkg::CMD_LEN-1:0] cmd_reg;
  logic [4:0]                  rise_reg;

  assign mem_di_o = cmd_reg[ecl_pkg::CMD_LEN-1];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_cs_o  <= 1'b0;
      mem_sck_o <= 1'b0;
      cmd_reg   <= '0;
      rise_reg  <= 5'h00;
      data_o    <= 16'h0000;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !mem_cs_o) begin
        mem_cs_o  <= 1'b1;
        mem_sck_o <= 1'b0;
        cmd_reg   <= {ecl_pkg::RD_OP, addr_i};
        rise_reg  <= 5'h00;
      end else if (tick_i && mem_cs_o) begin
        if (!mem_sck_o) begin
          mem_sck_o <= 1'b1;
          rise_reg  <= rise_reg + 5'h01;
          // The first sampled bit is the dummy zero; it shifts out
          if (rise_reg >= CMDL) begin
            data_o <= {data_o[ecl_pkg::DW-2:0], mem_do_i};
          end
        end else begin
          mem_sck_o <= 1'b0;
          cmd_reg   <= {cmd_reg[ecl_pkg::CMD_LEN-2:0], 1'b0};
          if (rise_reg == LAST) begin
            mem_cs_o <= 1'b0;
            done_o   <= 1'b1;
          end
        end
      end
    end
  end
endmodule // ecl_serial_reader
`default_nettype wire

// file: rtl/ecl_port_image.sv
// One port's copy of the loaded configuration register fields.
// Assumes apply_i is a one-cycle pulse with stable field images.
`timescale 1ns/1ns
`default_nettype none
module ecl_port_image #(
  parameter bit HAS_LBN = 1'b1
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  // Shared field images
  input  wire logic                 apply_i,
  input  wire logic [ecl_pkg::RW-1:0] img_cc_i,
  input  wire logic [ecl_pkg::RW-1:0] img_8c_i,
  input  wire logic [ecl_pkg::RW-1:0] img_e4_i,
  input  wire logic [ecl_pkg::RW-1:0] img_94_i,
  input  wire logic [ecl_pkg::RW-1:0] img_74_i,
  input  wire logic [ecl_pkg::RW-1:0] img_78_i,
  input  wire logic [ecl_pkg::RW-1:0] img_7c_i,
  input  wire logic [ecl_pkg::RW-1:0] img_90_i,
  input  wire logic [ecl_pkg::RW-1:0] img_84_i,
  input  wire logic [ecl_pkg::RW-1:0] img_88_i,
  input  wire logic [ecl_pkg::RW-1:0] img_98_i,
  // This port's registers
  output logic [ecl_pkg::RW-1:0]    cfg_cc_o,
  output logic [ecl_pkg::RW-1:0]    cfg_8c_o,
  output logic [ecl_pkg::RW-1:0]    cfg_e4_o,
  output logic [ecl_pkg::RW-1:0]    cfg_94_o,
  output logic [ecl_pkg::RW-1:0]    cfg_74_o,
  output logic [ecl_pkg::RW-1:0]    cfg_78_o,
  output logic [ecl_pkg::RW-1:0]    cfg_7c_o,
  output logic [ecl_pkg::RW-1:0]    cfg_90_o,
  output logic [ecl_pkg::RW-1:0]    cfg_84_o,
  output logic [ecl_pkg::RW-1:0]    cfg_88_o,
  output logic [ecl_pkg::RW-1:0]    cfg_98_o
);
  logic [ecl_pkg::RW-1:0] cc_next;

  // Port 0 has no bandwidth notification bit, so it stays clear
  always_comb begin
    cc_next = img_cc_i;
    cc_next[ecl_pkg::CC_LBN] = HAS_LBN & img_cc_i[ecl_pkg::CC_LBN];
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_cc_o <= '0;
      cfg_8c_o <= '0;
      cfg_e4_o <= '0;
      cfg_94_o <= '0;
      cfg_74_o <= '0;
      cfg_78_o <= '0;
      cfg_7c_o <= '0;
      cfg_90_o <= '0;
      cfg_84_o <= '0;
      cfg_88_o <= '0;
      cfg_98_o <= '0;
    end else if (apply_i) begin
      cfg_cc_o <= cc_next;
      cfg_8c_o <= img_8c_i;
      cfg_e4_o <= img_e4_i;
      cfg_94_o <= img_94_i;
      cfg_74_o <= img_74_i;
      cfg_78_o <= img_78_i;
      cfg_7c_o <= img_7c_i;
      cfg_90_o <= img_90_i;
      cfg_84_o <= img_84_i;
      cfg_88_o <= img_88_i;
      cfg_98_o <= img_98_i;
    end
  end
endmodule // ecl_port_image
`default_nettype wire

// file: rtl/ecl_loader.sv
// Port configuration loader: reads words 0Ch..1Eh from the serial
// memory and copies their fields into every port's registers, less the bandwidth bit on port 0.
// Assumes a three-wire serial memory and a 10 MHz sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
module ecl_loader (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          resetn_i,
  // Strap: high to read the memory, low to keep defaults
  input  wire logic          load_en_i,
  // Serial memory
  input  wire logic          mem_do_i,
  output logic               mem_cs_o,
  output logic               mem_sck_o,
  output logic               mem_di_o,
  // Status
  output logic               load_busy_o,
  output logic               load_done_o,
  // Port registers, port p in bits [32p+31:32p]
  output logic [127:0]       cfg_cc_o,
  output logic [127:0]       cfg_8c_o,
  output logic [127:0]       cfg_e4_o,
  output logic [127:0]       cfg_94_o,
  output logic [127:0]       cfg_74_o,
  output logic [127:0]       cfg_78_o,
  output logic [127:0]       cfg_7c_o,
  output logic [127:0]       cfg_90_o,
  output logic [127:0]       cfg_84_o,
  output logic [127:0]       cfg_88_o,
  output logic [127:0]       cfg_98_o
);
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_ISSUE,
    ST_WAIT,
    ST_APPLY,
    ST_DONE
  } ecl_state_t;

  localparam int WIW_L = ecl_pkg::WIW;
  localparam int RW_L  = ecl_pkg::RW;
  localparam int DW_L  = ecl_pkg::DW;
  localparam logic [WIW_L-1:0] LAST_W = 4'(ecl_pkg::NWORD - 1);
  localparam logic [2:0] SCK_LAST = 3'(ecl_pkg::SCK_HALF - 1);
  localparam logic [1:0] BOOT_LAST = 2'(ecl_pkg::BOOT_CYC - 1);

  ecl_state_t                 state_reg;
  logic [WIW_L-1:0]           widx_reg;
  logic [1:0]                 boot_reg;
  logic [2:0]                 div_reg;
  logic                       tick;
  logic                       rd_start;
  logic                       rd_done;
  logic [ecl_pkg::DW-1:0]     rd_data;
  logic [7:0]                 byte_addr;
  logic                       apply;
  logic                       do_meta_reg;
  logic                       do_sync_reg;
  logic                       en_meta_reg;
  logic                       en_sync_reg;
  logic [ecl_pkg::DW-1:0]     word_reg [ecl_pkg::NWORD];

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      do_meta_reg <= 1'b0;
      do_sync_reg <= 1'b0;
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      do_meta_reg <= mem_do_i;
      do_sync_reg <= do_meta_reg;
      en_meta_reg <= load_en_i;
      en_sync_reg <= en_meta_reg;
    end
  end

  // Serial clock rate enable
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg <= 3'h0;
    end else if (div_reg == SCK_LAST) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  assign tick = (div_reg == SCK_LAST);

  // Memory word address is the byte address halved
  assign byte_addr = 8'(ecl_pkg::FIRST_ADDR
                        + ecl_pkg::ADDR_STEP * widx_reg);

  // Load sequence
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_BOOT;
      boot_reg  <= 2'h0;
      widx_reg  <= '0;
    end else begin
      case (state_reg)
        ST_BOOT: begin
          // Wait for the strap to pass its synchroniser
          if (boot_reg == BOOT_LAST) begin
            state_reg <= en_sync_reg ? ST_ISSUE : ST_APPLY;
          end else begin
            boot_reg <= boot_reg + 2'h1;
          end
        end
        ST_ISSUE: begin
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (rd_done) begin
            if (widx_reg == LAST_W) begin
              state_reg <= ST_APPLY;
            end else begin
              widx_reg  <= widx_reg + 4'h1;
              state_reg <= ST_ISSUE;
            end
          end
        end
        ST_APPLY: begin
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          state_reg <= ST_DONE;
        end
        default: begin
          state_reg <= ST_BOOT;
        end
      endcase
    end
  end

  assign rd_start = (state_reg == ST_ISSUE);
  assign apply    = (state_reg == ST_APPLY);

  // Ports are held off until the images are in place
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_done_o <= 1'b0;
      load_busy_o <= 1'b1;
    end else if (apply) begin
      load_done_o <= 1'b1;
      load_busy_o <= 1'b0;
    end
  end

  // Word store, preset to the defaults so an unread word still loads
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_reg[ecl_pkg::W_CAP] <= ecl_pkg::DEF_CAP;
      word_reg[ecl_pkg::W_MGN] <= ecl_pkg::DEF_MGN;
      word_reg[ecl_pkg::W_NOM] <= ecl_pkg::DEF_NOM;
      word_reg[ecl_pkg::W_EMP] <= ecl_pkg::DEF_EMP;
      word_reg[ecl_pkg::W_PHY] <= ecl_pkg::DEF_PHY;
      word_reg[ecl_pkg::W_C4L] <= ecl_pkg::DEF_C4L;
      word_reg[ecl_pkg::W_C4H] <= ecl_pkg::DEF_C4H;
      word_reg[ecl_pkg::W_C5L] <= ecl_pkg::DEF_C5L;
      word_reg[ecl_pkg::W_C5H] <= ecl_pkg::DEF_C5H;
      word_reg[ecl_pkg::W_DLT] <= ecl_pkg::DEF_DLT;
    end else if (rd_done && state_reg == ST_WAIT) begin
      word_reg[widx_reg] <= rd_data;
    end
  end

  ecl_serial_reader u_reader (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .tick_i    (tick),
    .start_i   (rd_start),
    .addr_i    (byte_addr[ecl_pkg::MAW:1]),
    .done_o    (rd_done),
    .data_o    (rd_data),
    .mem_do_i  (do_sync_reg),
    .mem_cs_o  (mem_cs_o),
    .mem_sck_o (mem_sck_o),
    .mem_di_o  (mem_di_o)
  );

  // Named fields of the loaded words
  logic [ecl_pkg::DW-1:0] cap_w;
  logic [4:0] margin_drive_level_low_emph;
  logic [4:0] margin_drive_level_high_emph;
  logic [4:0] margin_drive_level_half_swing;
  logic [4:0] nominal_drive_level_low_emph;
  logic [4:0] nominal_drive_level_high_emph;
  logic [4:0] nominal_drive_level_half_swing;
  logic [4:0] post_emphasis_rate1_nominal;
  logic [4:0] post_emphasis_rate2_low_nominal;
  logic [4:0] post_emphasis_rate2_high_nominal;
  logic [3:0] transmit_phy_latency;
  logic [2:0] receiver_detect_time_us;
  logic [4:0] half_swing_post_emphasis_delta;
  logic [1:0] low_emph_drive_level_delta;
  logic       rate2_signalling_mode;
  logic       obff_enable;
  logic [RW_L-1:0] phy_interface_control4;
  logic [DW_L-1:0] phy_interface_control5_lo;
  logic [7:0] phy_interface_control5_hi;
  logic [7:0] phy_interface_control6;
  logic [4:0] ref_clock_buffer_control;

  assign cap_w = word_reg[ecl_pkg::W_CAP];
  assign margin_drive_level_low_emph =
    word_reg[ecl_pkg::W_MGN][4:0];
  assign margin_drive_level_high_emph =
    word_reg[ecl_pkg::W_MGN][9:5];
  assign margin_drive_level_half_swing =
    word_reg[ecl_pkg::W_MGN][14:10];
  assign obff_enable = word_reg[ecl_pkg::W_MGN][15];
  assign nominal_drive_level_low_emph =
    word_reg[ecl_pkg::W_NOM][4:0];
  assign nominal_drive_level_high_emph =
    word_reg[ecl_pkg::W_NOM][9:5];
  assign nominal_drive_level_half_swing =
    word_reg[ecl_pkg::W_NOM][14:10];
  assign rate2_signalling_mode = word_reg[ecl_pkg::W_NOM][15];
  assign post_emphasis_rate1_nominal =
    word_reg[ecl_pkg::W_EMP][4:0];
  assign post_emphasis_rate2_low_nominal =
    word_reg[ecl_pkg::W_EMP][9:5];
  assign post_emphasis_rate2_high_nominal =
    word_reg[ecl_pkg::W_EMP][14:10];
  assign transmit_phy_latency = word_reg[ecl_pkg::W_PHY][3:0];
  assign receiver_detect_time_us = word_reg[ecl_pkg::W_PHY][6:4];
  assign half_swing_post_emphasis_delta =
    word_reg[ecl_pkg::W_PHY][11:7];
  assign phy_interface_control4 =
    {word_reg[ecl_pkg::W_C4H], word_reg[ecl_pkg::W_C4L]};
  assign phy_interface_control5_lo = word_reg[ecl_pkg::W_C5L];
  assign phy_interface_control5_hi = word_reg[ecl_pkg::W_C5H][7:0];
  // Sixth control field is gathered from three words
  assign phy_interface_control6 = {
    word_reg[ecl_pkg::W_C5H][10:8],
    word_reg[ecl_pkg::W_PHY][15:12],
    word_reg[ecl_pkg::W_EMP][15]
  };
  assign ref_clock_buffer_control = word_reg[ecl_pkg::W_C5H][15:11];
  assign low_emph_drive_level_delta = word_reg[ecl_pkg::W_DLT][1:0];

  // Register images shared by every port; bits not loaded stay zero
  logic [RW_L-1:0] img_cc;
  logic [RW_L-1:0] img_8c;
  logic [RW_L-1:0] img_e4;
  logic [RW_L-1:0] img_94;
  logic [RW_L-1:0] img_74;
  logic [RW_L-1:0] img_78;
  logic [RW_L-1:0] img_7c;
  logic [RW_L-1:0] img_90;
  logic [RW_L-1:0] img_84;
  logic [RW_L-1:0] img_88;
  logic [RW_L-1:0] img_98;

  always_comb begin
    img_cc = '0;
    img_cc[ecl_pkg::CC_LBN] = cap_w[9];
    img_cc[ecl_pkg::CC_SDN] = cap_w[12];
    img_8c = '0;
    img_8c[ecl_pkg::C8_ORDF] = cap_w[10];
    img_8c[ecl_pkg::C8_SOF]  = cap_w[11];
    img_8c[ecl_pkg::C8_PMDS] = cap_w[13];
    img_8c[ecl_pkg::C8_4KB]  = cap_w[15];
    img_8c[ecl_pkg::C8_R2M]  = rate2_signalling_mode;
    img_8c[ecl_pkg::C8_P6LO] = phy_interface_control6[0];
    img_8c[ecl_pkg::C8_P6MID +: 4] =
      phy_interface_control6[4:1];
    img_8c[ecl_pkg::C8_P6HI +: 3] =
      phy_interface_control6[7:5];
    img_e4 = '0;
    img_e4[ecl_pkg::E4_LTR]  = cap_w[14];
    img_e4[ecl_pkg::E4_OBFF] = obff_enable;
    img_94 = {17'h00000,
              margin_drive_level_half_swing,
              margin_drive_level_high_emph,
              margin_drive_level_low_emph};
    img_74 = '0;
    img_74[ecl_pkg::HI_FLD +: 15] = {
      nominal_drive_level_half_swing,
      nominal_drive_level_high_emph,
      nominal_drive_level_low_emph};
    img_78 = '0;
    img_78[ecl_pkg::HI_FLD +: 15] = {
      post_emphasis_rate2_high_nominal,
      post_emphasis_rate2_low_nominal,
      post_emphasis_rate1_nominal};
    img_7c = {25'h0000000,
              receiver_detect_time_us,
              transmit_phy_latency};
    img_90 = '0;
    img_90[ecl_pkg::C90_HSD +: 5] =
      half_swing_post_emphasis_delta;
    img_90[ecl_pkg::C90_LED +: 2] =
      low_emph_drive_level_delta;
    img_84 = phy_interface_control4;
    img_88 = '0;
    img_88[DW_L-1:0] = phy_interface_control5_lo;
    img_88[ecl_pkg::HI_FLD +: 8] =
      phy_interface_control5_hi;
    img_98 = '0;
    img_98[ecl_pkg::C98_RCB +: 5] =
      ref_clock_buffer_control;
  end

  // One register copy per port; only port 0 lacks the bandwidth bit
  for (genvar p = 0; p < ecl_pkg::NPORT; p++) begin : g_port
    ecl_port_image #(
      .HAS_LBN (p != 0)
    ) u_img (
      .sys_clk_i (sys_clk_i),
      .resetn_i  (resetn_i),
      .apply_i   (apply),
      .img_cc_i  (img_cc),
      .img_8c_i  (img_8c),
      .img_e4_i  (img_e4),
      .img_94_i  (img_94),
      .img_74_i  (img_74),
      .img_78_i  (img_78),
      .img_7c_i  (img_7c),
      .img_90_i  (img_90),
      .img_84_i  (img_84),
      .img_88_i  (img_88),
      .img_98_i  (img_98),
      .cfg_cc_o  (cfg_cc_o[RW_L*p +: RW_L]),
      .cfg_8c_o  (cfg_8c_o[RW_L*p +: RW_L]),
      .cfg_e4_o  (cfg_e4_o[RW_L*p +: RW_L]),
      .cfg_94_o  (cfg_94_o[RW_L*p +: RW_L]),
      .cfg_74_o  (cfg_74_o[RW_L*p +: RW_L]),
      .cfg_78_o  (cfg_78_o[RW_L*p +: RW_L]),
      .cfg_7c_o  (cfg_7c_o[RW_L*p +: RW_L]),
      .cfg_90_o  (cfg_90_o[RW_L*p +: RW_L]),
      .cfg_84_o  (cfg_84_o[RW_L*p +: RW_L]),
      .cfg_88_o  (cfg_88_o[RW_L*p +: RW_L]),
      .cfg_98_o  (cfg_98_o[RW_L*p +: RW_L])
    );
  end
endmodule // ecl_loader
`default_nettype wire

// file: dv/ecl_mem_model.sv
// Behavioural three-wire serial memory of 64 16-bit words.
// Assumes the loader samples mem_do a few cycles after each sck rise.
`timescale 1ns/1ns
`default_nettype none
module ecl_mem_model (
  // Memory pins
  input  wire logic mem_cs_i,
  input  wire logic mem_sck_i,
  input  wire logic mem_di_i,
  output logic      mem_do_o
);
  logic [15:0] mem [64];
  logic [7:0]  cmd_reg;
  logic [15:0] data_reg;
  int          rise_cnt;
  initial mem_do_o = 1'b0;
  // Released line shows the inverse so a stale sample is caught
  always @(posedge mem_sck_i or negedge mem_cs_i) begin
    if (!mem_cs_i) begin
      rise_cnt <= 0;
      mem_do_o <= ~mem_do_o;
    end else begin
      rise_cnt <= rise_cnt + 1;
      cmd_reg  <= {cmd_reg[6:0], mem_di_i};
      if (rise_cnt == 8) begin
        data_reg <= (cmd_reg[7:5] == 3'b110) ?
          mem[{cmd_reg[4:0], mem_di_i}] : 16'h5A5A;
        mem_do_o <= 1'b0;
      end else if (rise_cnt > 8 && rise_cnt < 25) begin
        mem_do_o <= data_reg[15];
        data_reg <= {data_reg[14:0], 1'b0};
      end
    end
  end
endmodule // ecl_mem_model
`default_nettype wire

// file: dv/ecl_loader_asserts.sv
// Port-level checks of the configuration loader.
// Assumes the loader top module ecl_loader with its own port names.
`timescale 1ns/1ns
`default_nettype none
module ecl_loader_chk (
  // Clock and reset
  input wire logic         sys_clk_i,
  input wire logic         resetn_i,
  // Memory pins and status
  input wire logic         mem_cs_o,
  input wire logic         mem_sck_o,
  input wire logic         mem_di_o,
  input wire logic         load_busy_o,
  input wire logic         load_done_o,
  // Port registers
  input wire logic [127:0] cfg_cc_o,
  input wire logic [127:0] cfg_8c_o,
  input wire logic [127:0] cfg_e4_o,
  input wire logic [127:0] cfg_7c_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_busy_xor_done: assert property (load_busy_o ^ load_done_o)
    else $error("busy and done disagree");
  a_done_sticky: assert property (load_done_o |=> load_done_o)
    else $error("done dropped");
  a_zero_while_busy: assert property (load_busy_o |->
    cfg_cc_o == 0 && cfg_8c_o == 0 && cfg_e4_o == 0 && cfg_7c_o == 0)
    else $error("registers changed before load end");
  a_cfg_frozen: assert property (load_done_o |=> $stable(cfg_8c_o)
    && $stable(cfg_e4_o) && $stable(cfg_7c_o)) else $error("cfg moved");
  a_port0_no_lbn: assert property (cfg_cc_o[21] == 1'b0)
    else $error("port 0 advertises bandwidth notification");
  a_cc_unused: assert property ((cfg_cc_o & {4{32'hFFD7FFFF}}) == 0)
    else $error("stray cc bit");
  a_e4_unused: assert property ((cfg_e4_o & {4{32'hFFFBEFFF}}) == 0)
    else $error("stray e4 bit");
  a_7c_unused: assert property ((cfg_7c_o & {4{32'hFFFFFF80}}) == 0)
    else $error("stray 7c bit");
  a_ports_alike: assert property (cfg_8c_o == {4{cfg_8c_o[31:0]}}
    && cfg_cc_o[127:32] == {3{cfg_cc_o[63:32]}}) else $error("ports differ");
  a_sck_idle_low: assert property (!mem_cs_o |-> !mem_sck_o)
    else $error("sck high while deselected");
  a_sck_half: assert property ($rose(mem_sck_o) |->
    mem_sck_o [*4] ##1 !mem_sck_o) else $error("sck high time wrong");
  a_cs_open: assert property ($rose(mem_cs_o) |->
    mem_di_o && !mem_sck_o) else $error("bad word start");
endmodule // ecl_loader_chk
bind ecl_loader ecl_loader_chk chk_u (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .mem_cs_o(mem_cs_o), .mem_sck_o(mem_sck_o),
  .mem_di_o(mem_di_o), .load_busy_o(load_busy_o),
  .load_done_o(load_done_o), .cfg_cc_o(cfg_cc_o), .cfg_8c_o(cfg_8c_o),
  .cfg_e4_o(cfg_e4_o), .cfg_7c_o(cfg_7c_o));
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench: loads words from the memory model into the ports.
// Assumes a 10 MHz clock and words at byte addresses 0Ch to 1Eh.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        load_en_i = 1'b0;
  wire logic   mem_do, mem_cs, mem_sck, mem_di, busy, done;
  wire logic [127:0] cfg [11];
  int          error_cnt  = 0;
  int          n_compared = 0;
  logic [15:0] w [10];
  logic [15:0] defs [10] = '{16'h001D, 16'h916B, 16'h0A73, 16'hF6B5,
    16'hC0A7, 16'h0000, 16'h0000, 16'h3333, 16'h7B08, 16'h0000};
  always #50 sys_clk_i = ~sys_clk_i;
  ecl_loader dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .load_en_i(load_en_i), .mem_do_i(mem_do), .mem_cs_o(mem_cs),
    .mem_sck_o(mem_sck), .mem_di_o(mem_di), .load_busy_o(busy),
    .load_done_o(done), .cfg_cc_o(cfg[0]), .cfg_8c_o(cfg[1]),
    .cfg_e4_o(cfg[2]), .cfg_94_o(cfg[3]), .cfg_74_o(cfg[4]),
    .cfg_78_o(cfg[5]), .cfg_7c_o(cfg[6]), .cfg_90_o(cfg[7]),
    .cfg_84_o(cfg[8]), .cfg_88_o(cfg[9]), .cfg_98_o(cfg[10]));
  ecl_mem_model mem_u (.mem_cs_i(mem_cs), .mem_sck_i(mem_sck),
    .mem_di_i(mem_di), .mem_do_o(mem_do));
  task automatic finish_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic check_all();
    int o;
    for (int p = 0; p < 4; p++) begin
      o = 32 * p;
      check(cfg[0][o+:32], {10'h0, (p != 0) & w[0][9], 1'b0,
        w[0][12], 19'h0});
      check(cfg[1][o+:32], {w[2][15], 7'h0, w[8][10:8],
        w[4][15:12], w[3][15], 9'h0, w[0][10], 2'h0,
        w[0][15], 1'b0, w[0][13], w[0][11]});
      check(cfg[2][o+:32], {13'h0, w[1][15], 5'h0,
        w[0][14], 12'h0});
      check(cfg[3][o+:32], {17'h0, w[1][14:0]});
      check(cfg[4][o+:32], {1'b0, w[2][14:0], 16'h0});
      check(cfg[5][o+:32], {1'b0, w[3][14:0], 16'h0});
      check(cfg[6][o+:32], {25'h0, w[4][6:0]});
      check(cfg[7][o+:32], {10'h0, w[9][1:0], w[4][11:7], 15'h0});
      check(cfg[8][o+:32], {w[6], w[5]});
      check(cfg[9][o+:32], {8'h0, w[8][7:0], w[7]});
      check(cfg[10][o+:32], {11'h0, w[8][15:11], 16'h0});
      check(cfg[7][o+:32] & 32'h00300000, {10'h0, w[9][1:0], 20'h0});
    end
  endtask
  // Mode 0 random, 1 all ones, 2 all zeros; cut re-resets mid load
  task automatic run(logic en, int mode, int cut);
    int n;
    @(negedge sys_clk_i);
    resetn_i  = 1'b0;
    load_en_i = en;
    for (int i = 0; i < 64; i++) begin
      mem_u.mem[i] = (mode == 1) ? 16'hFFFF :
                     (mode == 2) ? 16'h0000 : 16'($urandom);
    end
    for (int i = 0; i < 10; i++) begin
      w[i] = en ? mem_u.mem[6 + i] : defs[i];
    end
    repeat (3) @(negedge sys_clk_i);
    check(busy, 1'b1);
    check(done, 1'b0);
    resetn_i = 1'b1;
    if (cut > 0) begin
      repeat (cut) @(negedge sys_clk_i);
      check(busy, 1'b1);
      check(cfg[8][31:0], 32'h0);
      resetn_i = 1'b0;
      @(negedge sys_clk_i);
      resetn_i = 1'b1;
    end
    for (n = 0; n < 5000 && done !== 1'b1; n++) @(negedge sys_clk_i);
    if (done !== 1'b1) begin
      check(done, 1'b1);
      finish_test();
    end else begin
      check(busy, 1'b0);
      check_all();
      repeat (20) @(negedge sys_clk_i);
      check_all();
    end
  endtask
  initial begin
    void'($urandom(32'h10a5d9db));
    run(1'b0, 0, 0);
    for (int k = 0; k < 3; k++) run(1'b1, 0, 0);
    run(1'b1, 1, 0);
    run(1'b1, 2, 0);
    run(1'b1, 0, 700);
    finish_test();
  end
endmodule // tb
`default_nettype wire
